// File: hw/bff_pkg.sv
// Constants of the Port B side and flag logic of a two-way FIFO.
// Assumes a classic Wishbone master with 32-bit data on the register side.

package bff_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADR_DATA   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CTRL   = 8'h08;
    localparam logic [7:0] ADR_AE_AB  = 8'h0c;
    localparam logic [7:0] ADR_AF_AB  = 8'h10;
    localparam logic [7:0] ADR_AE_BA  = 8'h14;
    localparam logic [7:0] ADR_AF_BA  = 8'h18;
    localparam logic [7:0] ADR_CNT_AB = 8'h1c;
    localparam logic [7:0] ADR_CNT_BA = 8'h20;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int CTRL_BYPASS_BIT = 0;
    localparam int ST_BYPASS_BIT   = 8;
    localparam int OFFSET_DEFAULT  = 8;
    localparam int DATA_W          = 18;

endpackage

// File: hw/bff_queue.sv
// One direction of the FIFO: memory array, pointers and word count.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps

module bff_queue #(
    parameter int WIDTH = 18,
    parameter int AW    = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] rdata,
    output logic      [AW:0]      count
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    rptr_reg;
    logic [AW:0]      count_reg;

    assign rdata = mem[rptr_reg];
    assign count = count_reg;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_reg] <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else if (clr) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: hw/bff_top.sv
// Port B pins, Wishbone stand-in for Port A, bypass mailboxes and all flags.
// Assumes Port B pins and the Wishbone master are synchronous to clk.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps

module bff_top #(
    parameter int AW = 8
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        device_reset_n,
    input  wire logic        port_b_direction,
    input  wire logic        port_b_transfer_gate_n,
    input  wire logic        port_b_drive_gate_n,
    input  wire logic [17:0] port_b_data_bus_i,
    output logic      [17:0] port_b_data_bus_o,
    output logic             port_b_data_bus_oe,
    output logic             a_to_b_empty_n,
    output logic             a_to_b_almost_empty_n,
    output logic             a_to_b_almost_full_n,
    output logic             a_to_b_full_n,
    output logic             b_to_a_empty_n,
    output logic             b_to_a_almost_empty_n,
    output logic             b_to_a_almost_full_n,
    output logic             b_to_a_full_n,
    output logic             port_b_bypass_active_n
);
    localparam int          DW    = bff_pkg::DATA_W;
    localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);
    localparam logic [AW:0] OFF_D = (AW+1)'(bff_pkg::OFFSET_DEFAULT);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic          ack_reg;
    logic [31:0]   rdat_reg;
    logic          bypass_reg;
    logic          bypass_next;
    logic [AW:0]   ae_ab_reg;
    logic [AW:0]   af_ab_reg;
    logic [AW:0]   ae_ba_reg;
    logic [AW:0]   af_ba_reg;
    logic          ab_mb_full_reg;
    logic          ab_mb_full_next;
    logic [DW-1:0] ab_mb_reg;
    logic          ba_mb_full_reg;
    logic          ba_mb_full_next;
    logic [DW-1:0] ba_mb_reg;
    logic [DW-1:0] bdo_reg;
    logic          boe_reg;
    logic [7:0]    flags_reg;
    logic          srst;
    logic          wb_req;
    logic          a_wr;
    logic          a_rd;
    logic          ctl_wr;
    logic          b_rd;
    logic          b_wr;
    logic          ab_push;
    logic          ab_pop;
    logic          ba_push;
    logic          ba_pop;
    logic          ab_mb_load;
    logic          ab_mb_take;
    logic          ba_mb_load;
    logic          ba_mb_take;
    logic [AW:0]   ab_cnt;
    logic [AW:0]   ba_cnt;
    logic [AW:0]   ab_cnt_next;
    logic [AW:0]   ba_cnt_next;
    logic [DW-1:0] ab_rdata;
    logic [DW-1:0] ba_rdata;
    logic [7:0]    flags_next;

    function automatic logic [AW:0] cnt_next(input logic [AW:0] c, input logic inc,
                                             input logic dec);
        logic [AW:0] r;
        r = c;
        if (inc && !dec) begin
            r = c + 1'b1;
        end else if (dec && !inc) begin
            r = c - 1'b1;
        end
        return r;
    endfunction

    function automatic logic [AW:0] wr_off(input logic [31:0] d);
        return d[AW:0];
    endfunction

    // ************************************************************
    // Request decode
    // ************************************************************
    assign srst   = !device_reset_n;
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg && !srst;
    assign a_wr   = wb_req && wb_we_i && (wb_adr_i == bff_pkg::ADR_DATA) && (wb_sel_i != 4'h0);
    assign a_rd   = wb_req && !wb_we_i && (wb_adr_i == bff_pkg::ADR_DATA);
    assign ctl_wr = wb_req && wb_we_i && (wb_sel_i != 4'h0);
    assign b_rd   = !port_b_transfer_gate_n && port_b_direction && !srst;
    assign b_wr   = !port_b_transfer_gate_n && !port_b_direction && !srst;

    assign ab_push = a_wr && !bypass_reg && (ab_cnt != DEPTH);
    assign ab_pop  = b_rd && !bypass_reg && (ab_cnt != '0);
    assign ba_push = b_wr && !bypass_reg && (ba_cnt != DEPTH);
    assign ba_pop  = a_rd && !bypass_reg && (ba_cnt != '0);

    assign ab_mb_load = a_wr && bypass_reg && !ab_mb_full_reg;
    assign ab_mb_take = b_rd && bypass_reg && ab_mb_full_reg;
    assign ba_mb_load = b_wr && bypass_reg && !ba_mb_full_reg;
    assign ba_mb_take = a_rd && bypass_reg && ba_mb_full_reg;

    assign ab_cnt_next = cnt_next(ab_cnt, ab_push, ab_pop);
    assign ba_cnt_next = cnt_next(ba_cnt, ba_push, ba_pop);

    // ************************************************************
    // Queues
    // ************************************************************
    bff_queue #(.WIDTH(DW), .AW(AW)) u_ab (
        .clk   (clk),
        .rst   (rst),
        .clr   (srst),
        .push  (ab_push),
        .wdata (wb_dat_i[DW-1:0]),
        .pop   (ab_pop),
        .rdata (ab_rdata),
        .count (ab_cnt)
    );

    bff_queue #(.WIDTH(DW), .AW(AW)) u_ba (
        .clk   (clk),
        .rst   (rst),
        .clr   (srst),
        .push  (ba_push),
        .wdata (port_b_data_bus_i),
        .pop   (ba_pop),
        .rdata (ba_rdata),
        .count (ba_cnt)
    );

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bypass_reg <= 1'b0;
            ae_ab_reg  <= OFF_D;
            af_ab_reg  <= OFF_D;
            ae_ba_reg  <= OFF_D;
            af_ba_reg  <= OFF_D;
        end else if (srst) begin
            bypass_reg <= 1'b0;
            ae_ab_reg  <= OFF_D;
            af_ab_reg  <= OFF_D;
            ae_ba_reg  <= OFF_D;
            af_ba_reg  <= OFF_D;
        end else if (ctl_wr) begin
            case (wb_adr_i)
                bff_pkg::ADR_CTRL:  bypass_reg <= bypass_next;
                bff_pkg::ADR_AE_AB: ae_ab_reg  <= wr_off(wb_dat_i);
                bff_pkg::ADR_AF_AB: af_ab_reg  <= wr_off(wb_dat_i);
                bff_pkg::ADR_AE_BA: ae_ba_reg  <= wr_off(wb_dat_i);
                bff_pkg::ADR_AF_BA: af_ba_reg  <= wr_off(wb_dat_i);
                default: ;
            endcase
        end
    end

    always_comb begin
        bypass_next = bypass_reg;
        if (srst) begin
            bypass_next = 1'b0;
        end else if (ctl_wr && (wb_adr_i == bff_pkg::ADR_CTRL)) begin
            bypass_next = wb_dat_i[bff_pkg::CTRL_BYPASS_BIT];
        end
    end

    // ************************************************************
    // Bypass mailboxes
    // ************************************************************
    assign ab_mb_full_next = srst ? 1'b0 : (ab_mb_load || (ab_mb_full_reg && !ab_mb_take));
    assign ba_mb_full_next = srst ? 1'b0 : (ba_mb_load || (ba_mb_full_reg && !ba_mb_take));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ab_mb_full_reg <= 1'b0;
            ba_mb_full_reg <= 1'b0;
            ab_mb_reg      <= '0;
            ba_mb_reg      <= '0;
        end else begin
            ab_mb_full_reg <= ab_mb_full_next;
            ba_mb_full_reg <= ba_mb_full_next;
            if (ab_mb_load) begin
                ab_mb_reg <= wb_dat_i[DW-1:0];
            end
            if (ba_mb_load) begin
                ba_mb_reg <= port_b_data_bus_i;
            end
        end
    end

    // ************************************************************
    // Port B output side
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bdo_reg <= '0;
            boe_reg <= 1'b0;
        end else begin
            boe_reg <= port_b_direction && !port_b_drive_gate_n;
            if (ab_pop) begin
                bdo_reg <= ab_rdata;
            end else if (ab_mb_take) begin
                bdo_reg <= ab_mb_reg;
            end
        end
    end

    assign port_b_data_bus_o  = bdo_reg;
    assign port_b_data_bus_oe = boe_reg;

    // ************************************************************
    // Flags, computed from the state after this edge, with the offsets from before it
    // ************************************************************
    always_comb begin
        flags_next[0] = bypass_next ? ab_mb_full_next : (ab_cnt_next != '0);
        flags_next[1] = ab_cnt_next > ae_ab_reg;
        flags_next[2] = ab_cnt_next <= (DEPTH - af_ab_reg);
        flags_next[3] = bypass_next ? !ab_mb_full_next : (ab_cnt_next != DEPTH);
        flags_next[4] = bypass_next ? ba_mb_full_next : (ba_cnt_next != '0);
        flags_next[5] = ba_cnt_next > ae_ba_reg;
        flags_next[6] = ba_cnt_next <= (DEPTH - af_ba_reg);
        flags_next[7] = bypass_next ? !ba_mb_full_next : (ba_cnt_next != DEPTH);
        if (srst) begin
            flags_next = 8'h8c;
            flags_next[6] = 1'b1;
            flags_next[2] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= 8'hcc;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign a_to_b_empty_n         = flags_reg[0];
    assign a_to_b_almost_empty_n  = flags_reg[1];
    assign a_to_b_almost_full_n   = flags_reg[2];
    assign a_to_b_full_n          = flags_reg[3];
    assign b_to_a_empty_n         = flags_reg[4];
    assign b_to_a_almost_empty_n  = flags_reg[5];
    assign b_to_a_almost_full_n   = flags_reg[6];
    assign b_to_a_full_n          = flags_reg[7];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_b_bypass_active_n <= 1'b1;
        end else begin
            port_b_bypass_active_n <= !bypass_next;
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg  <= 1'b0;
            rdat_reg <= '0;
        end else begin
            ack_reg  <= wb_cyc_i && wb_stb_i && !ack_reg;
            if (wb_cyc_i && wb_stb_i && !ack_reg) begin
                rdat_reg <= '0;
                if (!wb_we_i) begin
                    case (wb_adr_i)
                        bff_pkg::ADR_DATA:   rdat_reg[DW-1:0] <= ba_pop ? ba_rdata :
                                                 (ba_mb_take ? ba_mb_reg : '0);
                        bff_pkg::ADR_STATUS: rdat_reg[8:0] <= {bypass_reg, flags_reg};
                        bff_pkg::ADR_CTRL:   rdat_reg[bff_pkg::CTRL_BYPASS_BIT] <= bypass_reg;
                        bff_pkg::ADR_AE_AB:  rdat_reg[AW:0] <= ae_ab_reg;
                        bff_pkg::ADR_AF_AB:  rdat_reg[AW:0] <= af_ab_reg;
                        bff_pkg::ADR_AE_BA:  rdat_reg[AW:0] <= ae_ba_reg;
                        bff_pkg::ADR_AF_BA:  rdat_reg[AW:0] <= af_ba_reg;
                        bff_pkg::ADR_CNT_AB: rdat_reg[AW:0] <= ab_cnt;
                        bff_pkg::ADR_CNT_BA: rdat_reg[AW:0] <= ba_cnt;
                        default: ;
                    endcase
                end
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ab_empty;
        !bypass_reg |-> (a_to_b_empty_n == (ab_cnt != '0));
    endproperty
    a_ab_empty: assert property (p_ab_empty) else $error("A-to-B empty flag wrong");

    property p_ab_ae;
        !$past(srst) |-> (a_to_b_almost_empty_n == (ab_cnt > $past(ae_ab_reg)));
    endproperty
    a_ab_ae: assert property (p_ab_ae) else $error("A-to-B almost-empty wrong");

    property p_ab_af;
        !$past(srst) |-> (a_to_b_almost_full_n == (ab_cnt <= DEPTH - $past(af_ab_reg)));
    endproperty
    a_ab_af: assert property (p_ab_af) else $error("A-to-B almost-full wrong");

    property p_ba_full;
        !bypass_reg && !srst |=> (b_to_a_full_n == (ba_cnt != DEPTH)) || bypass_reg;
    endproperty
    a_ba_full: assert property (p_ba_full) else $error("B-to-A full flag wrong");

    property p_gate_idle;
        port_b_transfer_gate_n && !wb_req && !srst |=> $stable(ab_cnt) && $stable(ba_cnt);
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("Transfer while gate high");

    property p_drive;
        port_b_direction && !port_b_drive_gate_n |=> port_b_data_bus_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("Bus not driven");

    property p_release;
        port_b_drive_gate_n |=> !port_b_data_bus_oe;
    endproperty
    a_release: assert property (p_release) else $error("Bus driven with gate high");

    property p_byp_take;
        bypass_reg && b_rd && ab_mb_full_reg && !a_wr && !ctl_wr |=> !a_to_b_empty_n;
    endproperty
    a_byp_take: assert property (p_byp_take) else $error("Empty not low after take");

    property p_reset_flags;
        srst |=> !a_to_b_empty_n && !b_to_a_empty_n && a_to_b_full_n && b_to_a_full_n
                 && port_b_bypass_active_n;
    endproperty
    a_reset_flags: assert property (p_reset_flags) else $error("Reset flag state wrong");
endmodule

// File: bench/bff_host.sv
// Port B host model: drives direction, gates and write data of Port B.
// Assumes it shares the design's clock and that the bench calls xfer in turn.
`timescale 1ns/1ps

module bff_host (
    input  wire logic        clk,
    output logic             port_b_direction,
    output logic             port_b_transfer_gate_n,
    output logic             port_b_drive_gate_n,
    output logic [17:0]      data_o,
    input  wire logic [17:0] data_i
);
    initial begin
        port_b_direction       = 1'b0;
        port_b_transfer_gate_n = 1'b1;
        port_b_drive_gate_n    = 1'b1;
        data_o                 = 18'h00000;
    end

    // ************************************************************
    // One Port B cycle; gate low for one edge when go is set
    // ************************************************************
    task automatic xfer(input logic dir, input logic go, input logic [17:0] wd,
                        output logic [17:0] rd);
        @(posedge clk);
        port_b_direction       <= dir;
        port_b_transfer_gate_n <= ~go;
        port_b_drive_gate_n    <= ~dir;
        data_o                 <= wd;
        @(posedge clk);
        port_b_transfer_gate_n <= 1'b1;
        port_b_drive_gate_n    <= 1'b1;
        data_o                 <= ~wd;
        @(negedge clk);
        rd = data_i;
    endtask
endmodule

// File: bench/bff_top_tb.sv
// Self-checking bench of bff_top against a queue model.
// Assumes one shared clock; every Wishbone wait is bounded by a timeout.
`timescale 1ns/1ps

module bff_top_tb;
    logic        clk, rst, cyc, stb, we, dev_rst_n;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, r;
    logic        ack, dir, gate_n, drv_n, oe;
    logic [17:0] bus_in, bus_out, rd;
    logic        ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n;
    int          miscompares, n_compared, seed, i, d, ae_ab, mb_ab, mb_ba, last;
    int          ab[$], ba[$];
    bit          byp;

    bff_top bff_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .device_reset_n(dev_rst_n), .port_b_direction(dir),
        .port_b_transfer_gate_n(gate_n), .port_b_drive_gate_n(drv_n),
        .port_b_data_bus_i(bus_in), .port_b_data_bus_o(bus_out), .port_b_data_bus_oe(oe),
        .a_to_b_empty_n(ab_e), .a_to_b_almost_empty_n(ab_ae), .a_to_b_almost_full_n(ab_af),
        .a_to_b_full_n(ab_f), .b_to_a_empty_n(ba_e), .b_to_a_almost_empty_n(ba_ae),
        .b_to_a_almost_full_n(ba_af), .b_to_a_full_n(ba_f), .port_b_bypass_active_n(byp_n));

    bff_host bff_host_inst (.clk(clk), .port_b_direction(dir),
        .port_b_transfer_gate_n(gate_n), .port_b_drive_gate_n(drv_n),
        .data_o(bus_in), .data_i(bus_out));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ************************************************************
    // Comparison, verdict and Wishbone cycle
    // ************************************************************
    task automatic end_sim();
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask

    task automatic fl(input logic s, input bit e);
        chk({31'h0, s}, {31'h0, e});
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv,
                      output logic [31:0] rv);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= dv;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                miscompares++;
                end_sim();
            end
        end while (ack !== 1'b1);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(negedge clk);
    endtask

    task automatic flags();
        if (!byp) begin
            fl(ab_e, ab.size() != 0);
            fl(ab_ae, ab.size() > ae_ab);
            fl(ab_af, ab.size() <= 256 - bff_pkg::OFFSET_DEFAULT);
            fl(ab_f, ab.size() != 256);
            fl(ba_e, ba.size() != 0);
            fl(ba_ae, ba.size() > bff_pkg::OFFSET_DEFAULT);
            fl(ba_af, ba.size() <= 256 - bff_pkg::OFFSET_DEFAULT);
            fl(ba_f, ba.size() != 256);
        end else begin
            fl(ab_e, mb_ab >= 0);
            fl(ab_f, mb_ab < 0);
            fl(ba_e, mb_ba >= 0);
            fl(ba_f, mb_ba < 0);
        end
        fl(byp_n, !byp);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        miscompares = 0;
        n_compared  = 0;
        seed  = 86769;
        ae_ab = 8;
        last  = 0;
        mb_ab = -1;
        mb_ba = -1;
        byp   = 1'b0;
        rst   = 1'b1;
        cyc   = 1'b0;
        stb   = 1'b0;
        we    = 1'b0;
        adr   = 8'h00;
        wdat  = 32'h00000000;
        dev_rst_n = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        flags();
        wb(1'b0, bff_pkg::ADR_AE_AB, 32'h0, r);
        chk(r, 32'h00000008);
        wb(1'b0, 8'h3c, 32'h0, r);
        chk(r, 32'h00000000);
        wb(1'b1, bff_pkg::ADR_AE_AB, 32'h2, r);
        ae_ab = 2;
        for (i = 0; i < 257; i++) begin
            d = $random(seed) & 32'h3ffff;
            wb(1'b1, bff_pkg::ADR_DATA, d, r);
            if (ab.size() < 256) ab.push_back(d);
            flags();
        end
        wb(1'b0, bff_pkg::ADR_CNT_AB, 32'h0, r);
        chk(r, ab.size());
        for (i = 0; i < 258; i++) begin
            bff_host_inst.xfer(1'b1, i != 5, 18'h0, rd);
            if (i != 5 && ab.size() > 0) begin
                last = ab.pop_front();
                chk({14'h0, rd}, last);
                fl(oe, 1'b1);
            end else begin
                chk({14'h0, rd}, last);
            end
            flags();
        end
        for (i = 0; i < 20; i++) begin
            d = $random(seed) & 32'h3ffff;
            bff_host_inst.xfer(1'b0, i != 3, d[17:0], rd);
            fl(oe, 1'b0);
            if (i != 3) ba.push_back(d);
            flags();
        end
        for (i = 0; i < 21; i++) begin
            wb(1'b0, bff_pkg::ADR_DATA, 32'h0, r);
            chk(r, ba.size() > 0 ? ba.pop_front() : 0);
            flags();
        end
        wb(1'b1, bff_pkg::ADR_CTRL, 32'h1, r);
        byp = 1'b1;
        flags();
        d = $random(seed) & 32'h3ffff;
        wb(1'b1, bff_pkg::ADR_DATA, d, r);
        mb_ab = d;
        flags();
        wb(1'b1, bff_pkg::ADR_DATA, d ^ 1, r);
        flags();
        bff_host_inst.xfer(1'b1, 1'b1, 18'h0, rd);
        chk({14'h0, rd}, mb_ab);
        mb_ab = -1;
        flags();
        d = $random(seed) & 32'h3ffff;
        bff_host_inst.xfer(1'b0, 1'b1, d[17:0], rd);
        mb_ba = d;
        flags();
        wb(1'b0, bff_pkg::ADR_DATA, 32'h0, r);
        chk(r, mb_ba);
        mb_ba = -1;
        flags();
        wb(1'b1, bff_pkg::ADR_DATA, 32'h15, r);
        @(posedge clk);
        dev_rst_n <= 1'b0;
        @(posedge clk);
        dev_rst_n <= 1'b1;
        @(negedge clk);
        byp   = 1'b0;
        ae_ab = 8;
        flags();
        wb(1'b0, bff_pkg::ADR_AE_AB, 32'h0, r);
        chk(r, 32'h00000008);
        wb(1'b0, bff_pkg::ADR_STATUS, 32'h0, r);
        chk(r, 32'h000000cc);
        wb(1'b1, bff_pkg::ADR_CTRL, 32'h1, r);
        byp = 1'b1;
        flags();
        end_sim();
    end
endmodule
